/* File: rtl/cmd_interp.sv */
// Purpose: Executes configuration commands received on two byte ports.
// Assumes: Command framing: opcode, optional index and value bytes, then CR.
// Notes: Stored copy is modelled as a register array standing in for EEPROM.
`default_nettype none
module cmd_interp
  import cmd_interp_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Terminal port bytes
  input wire logic i_term_valid,
  input wire logic [7:0] i_term_data,
  // Host port bytes
  input wire logic i_host_valid,
  input wire logic [7:0] i_host_data,
  // Reply bytes
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  // Status
  output logic o_ready,
  output logic o_warn,
  output logic o_saved
);
  typedef struct packed {
    phase_type ph;
    logic [7:0] op;
    logic [IDX_W-1:0] idx;
    logic bad;
    logic [IDX_W-1:0] cnt;
    logic ready;
    logic warn;
    logic saved;
    logic tx_valid;
    logic [7:0] tx_data;
  } state_type;

  state_type s_q, s_d;
  logic [7:0] work_q [NUM_PARAMS];
  // Power-on content; survives reset, as a stored copy must
  logic [7:0] store_q [NUM_PARAMS] = '{default: PARAM_RESET};
  logic in_valid;
  logic [7:0] in_data;
  logic wr_en;
  logic [7:0] wr_val;

  // Host port loses a tie; the terminal is the service channel
  assign in_valid = i_term_valid | i_host_valid;
  assign in_data = i_term_valid ? i_term_data : i_host_data;

  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_val = in_data;
    s_d.warn = 1'b0;
    s_d.saved = 1'b0;
    s_d.tx_valid = 1'b0;
    unique case (s_q.ph)
      ST_BOOT: begin
        // Copy stored set into working set, one entry per cycle
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt == IDX_W'(NUM_PARAMS - 1)) begin
          s_d.ph = ST_OP;
          s_d.ready = 1'b1;
        end
      end
      ST_OP: begin
        if (in_valid && in_data != CMD_TERM) begin
          s_d.op = in_data;
          s_d.bad = !(in_data inside {OP_PARAM_MODE, OP_READ_MODE, OP_WRITE,
            OP_SAVE, OP_QUERY});
          s_d.ph = (in_data == OP_WRITE) ? ST_ARG1 : ST_WAIT;
        end
      end
      ST_ARG1: begin
        if (in_valid) begin
          s_d.idx = in_data[IDX_W-1:0];
          s_d.bad = in_data >= 8'(NUM_PARAMS);
          s_d.ph = ST_ARG2;
        end
      end
      ST_ARG2: begin
        // A rejected index still consumes its value byte
        if (in_valid) begin
          if (!s_q.bad) begin
            wr_en = 1'b1;
          end
          s_d.warn = s_q.bad;
          s_d.ph = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (in_valid && in_data == CMD_TERM) begin
          // Executed on the terminator; only the save echo is held back until the copy ends
          s_d.ph = ST_OP;
          if (s_q.bad && s_q.op != OP_WRITE) begin
            s_d.warn = 1'b1;
          end else if (!s_q.bad) begin
            s_d.tx_valid = 1'b1;
            s_d.tx_data = s_q.op;
            if (s_q.op == OP_PARAM_MODE) begin
              s_d.ready = 1'b0;
            end
            if (s_q.op == OP_READ_MODE) begin
              s_d.ready = 1'b1;
            end
            if (s_q.op == OP_QUERY) begin
              // Query answers with tagged encoding instead of an echo
              s_d.tx_data = QUERY_TAG ^ work_q[TRIG_PARAM_IDX];
            end
            if (s_q.op == OP_SAVE) begin
              s_d.tx_valid = 1'b0;
              s_d.cnt = '0;
              s_d.ph = ST_SAVE;
            end
          end
        end
      end
      ST_SAVE: begin
        // Port bytes during the save are dropped
        // Echo waits for the copy so the sender knows the save is safe
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt == IDX_W'(NUM_PARAMS - 1)) begin
          s_d.ph = ST_OP;
          s_d.saved = 1'b1;
          s_d.tx_valid = 1'b1;
          s_d.tx_data = OP_SAVE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{ph: ST_BOOT, op: 8'h00, idx: '0, bad: 1'b0, cnt: '0, ready: 1'b0,
        warn: 1'b0, saved: 1'b0, tx_valid: 1'b0, tx_data: 8'h00};
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // Arrays have no reset: boot copy defines the working set
  always_ff @(posedge i_clock) begin
    if (i_ce) begin
      if (s_q.ph == ST_BOOT) begin
        work_q[s_q.cnt] <= store_q[s_q.cnt];
      end else if (wr_en) begin
        work_q[s_q.idx] <= wr_val;
      end
      if (s_q.ph == ST_SAVE) begin
        store_q[s_q.cnt] <= work_q[s_q.cnt];
      end
    end
  end

  assign o_tx_valid = s_q.tx_valid;
  assign o_tx_data = s_q.tx_data;
  assign o_ready = s_q.ready;
  assign o_warn = s_q.warn;
  assign o_saved = s_q.saved;

  AST_PARAM_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_WAIT && in_valid && in_data == CMD_TERM && !s_q.bad
      && s_q.op == OP_PARAM_MODE) |=> !o_ready && o_tx_valid)
    else $error("ready not dropped by parameter mode");
  AST_READ_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_WAIT && in_valid && in_data == CMD_TERM && !s_q.bad
      && s_q.op == OP_READ_MODE) |=> o_ready)
    else $error("ready not raised by reading mode");
  AST_SAVE_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(s_q.ph == ST_SAVE) && i_ce |-> ##[7:64] o_saved)
    else $error("save did not finish");
  AST_BOOT_READY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.ph == ST_BOOT) |-> !o_ready)
    else $error("ready during boot load");
  AST_WARN_BAD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_ARG2 && in_valid && s_q.bad) |=> o_warn && !o_tx_valid)
    else $error("rejected value gave no warning");
  AST_NO_STORE_WR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.ph != ST_SAVE) |=> $stable(store_q[0]))
    else $error("stored copy changed outside save");
  AST_QUERY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_WAIT && in_valid && in_data == CMD_TERM && !s_q.bad
      && s_q.op == OP_QUERY) |=> o_tx_valid && o_tx_data == (QUERY_TAG ^ work_q[0]))
    else $error("query reply wrong");
  AST_ECHO_WHEN_OK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_warn |-> !o_tx_valid)
    else $error("echo on a warned command");
  AST_TERM_WINS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_OP && i_term_valid && i_host_valid && i_term_data != CMD_TERM)
      |=> s_q.op == $past(i_term_data))
    else $error("host byte won a tie with the terminal");
  AST_WRITE_LANDS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_ARG2 && in_valid && !s_q.bad)
      |=> work_q[$past(s_q.idx)] == $past(in_data))
    else $error("accepted value missing from working set");
  AST_WRITE_ECHO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_WAIT && in_valid && in_data == CMD_TERM && !s_q.bad
      && s_q.op == OP_WRITE) |=> o_tx_valid && o_tx_data == OP_WRITE)
    else $error("write not echoed at its terminator");
  AST_BAD_OP_WARN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_WAIT && in_valid && in_data == CMD_TERM && s_q.bad
      && s_q.op != OP_WRITE) |=> o_warn && !o_tx_valid)
    else $error("unknown command gave no warning");
  AST_SAVE_ECHO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_saved |-> o_tx_valid && o_tx_data == OP_SAVE)
    else $error("save finished without its echo");
  AST_BOOT_DONE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && s_q.ph == ST_BOOT && s_q.cnt == IDX_W'(NUM_PARAMS - 1)) |=> o_ready)
    else $error("reading mode not entered after boot load");
  // Enable low must hold every field, pulses included
  AST_CE_FREEZE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_ce |=> $stable(s_q))
    else $error("state moved while clock enable low");

  COV_SAVE: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_saved);
  COV_WARN: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_warn);
  COV_PMODE: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(o_ready));
  COV_HOST: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_host_valid && !i_term_valid && s_q.ph == ST_OP);
  COV_TIE: cover property (@(posedge i_clock) disable iff (!i_rst_n) i_term_valid && i_host_valid);
endmodule
`default_nettype wire

/* File: rtl/cmd_interp_pkg.sv */
// Purpose: Constants and types for the configuration command interpreter.
// Assumes: Commands arrive as pre-parsed byte strobes from two serial ports.
// Notes: Overview list below; the interpreter itself is in cmd_interp.sv.
// Overview of operation
// - Command bytes are accepted from both the terminal port and the host port.
// - A command runs as soon as its terminating byte arrives, with no confirm step; a write lands on its value byte.
// - Parameter writes change only the working set, never the stored copy.
// - The save command copies the whole working set to the stored copy.
// - A well-formed command is echoed back, except the query which answers instead.
// - The parameter-mode command leaves reading mode and drops the ready indicator.
// - The reading-mode command resumes reading and raises the ready indicator.
// - The trigger query returns the reading-pulse parameter (entry 0) in encoded form.
// - Each unknown parameter or rejected value raises its own warning pulse.
`default_nettype none
package cmd_interp_pkg;
  localparam int NUM_PARAMS = 8;
  localparam int IDX_W = 3;
  localparam logic [7:0] CMD_TERM = 8'h0D;
  // Single-character opcodes of the simplified command language
  localparam logic [7:0] OP_PARAM_MODE = 8'h50;
  localparam logic [7:0] OP_READ_MODE = 8'h52;
  localparam logic [7:0] OP_WRITE = 8'h57;
  localparam logic [7:0] OP_SAVE = 8'h45;
  localparam logic [7:0] OP_QUERY = 8'h3F;
  localparam logic [IDX_W-1:0] TRIG_PARAM_IDX = 3'h0;
  localparam logic [7:0] QUERY_TAG = 8'h54;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  typedef enum logic [2:0] {ST_BOOT, ST_OP, ST_ARG1, ST_ARG2, ST_WAIT, ST_SAVE}
    phase_type;
endpackage
`default_nettype wire

/* File: test/cmd_host_model.sv */
// Purpose: Far-side sender of command strings, one byte strobe per cycle.
// Assumes: Bytes launched 1 ns after the rising edge and held one cycle.
// Notes: A released data line shows the inverse of the last byte.
`default_nettype none
module cmd_host_model (
  // Clock
  input wire logic i_clock,
  // Byte strobe and data
  output logic o_valid,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
  end
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge i_clock);
      #1;
      o_valid = 1'b1;
      o_data = b[i];
    end
    @(posedge i_clock);
    #1;
    o_valid = 1'b0;
    o_data = ~o_data;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Terminal and host ports each fed by a sender model.
// Notes: Expected replies and warnings queue up and are matched in order.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_interp_pkg::*;
  logic i_clock, i_rst_n, ce, tv, hv, tx_v, rdy, warn, saved;
  logic [7:0] td, hd, tx_d, v1, v2;
  int bad_count = 0;
  int tests_run = 0;
  int n_ce;
  // Expected event: {saved, warn, reply strobe, reply byte}
  logic [10:0] exp_q[$];
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  cmd_interp DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_term_valid(tv), .i_term_data(td), .i_host_valid(hv), .i_host_data(hd),
    .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_ready(rdy), .o_warn(warn), .o_saved(saved));
  cmd_host_model trm (.i_clock(i_clock), .o_valid(tv), .o_data(td));
  cmd_host_model hst (.i_clock(i_clock), .o_valid(hv), .o_data(hd));
  task automatic cmp_event(input logic [10:0] e, input logic [10:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t event %3h expected %3h", $time, g, e);
    end
  endtask
  task automatic cmp_level(input logic e, input logic g, input string m);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Replies and warnings come out at most one per cycle; compare in order
  always @(posedge i_clock) begin
    if (i_rst_n && (tx_v !== 1'b0 || warn !== 1'b0 || saved !== 1'b0)) begin
      if (exp_q.size() == 0) begin
        cmp_level(1'b0, 1'b1, "unexpected output");
      end else begin
        cmp_event(exp_q.pop_front(), {saved, warn, tx_v, tx_v ? tx_d : 8'h00});
      end
    end
  end
  task automatic drain(input logic exp_rdy);
    for (int n = 0; n < 40 && !(exp_q.size() == 0 && rdy === exp_rdy); n++) begin
      @(posedge i_clock);
      #1;
    end
    if (exp_q.size() != 0 || rdy !== exp_rdy) begin
      cmp_level(1'b0, 1'b1, "timeout or wrong ready level");
      report_and_stop();
    end else begin
      cmp_level(exp_rdy, rdy, "ready level");
    end
  endtask
  task automatic reset_dut;
    @(posedge i_clock);
    #1;
    i_rst_n = 1'b0;
    repeat (8) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    drain(1'b1);
  endtask
  initial begin
    i_rst_n = 1'b0;
    ce = 1'b1;
    void'($urandom(34));
    v1 = 8'($urandom());
    v2 = v1 ^ 8'h5A;
    n_ce = 1 + int'($urandom_range(7, 0));
    reset_dut();
    exp_q.push_back({3'h1, QUERY_TAG});
    trm.send('{OP_QUERY, CMD_TERM});
    exp_q.push_back({3'h1, OP_WRITE});
    hst.send('{OP_WRITE, 8'h00, v1, CMD_TERM});
    exp_q.push_back({3'h1, QUERY_TAG ^ v1});
    trm.send('{OP_QUERY, CMD_TERM});
    exp_q.push_back({3'h5, OP_SAVE});
    hst.send('{OP_SAVE, CMD_TERM}); // Save goes last from the host
    drain(1'b1);
    exp_q.push_back({3'h1, OP_PARAM_MODE});
    trm.send('{OP_PARAM_MODE, CMD_TERM});
    drain(1'b0);
    exp_q.push_back({3'h1, OP_READ_MODE});
    hst.send('{OP_READ_MODE, CMD_TERM});
    drain(1'b1);
    // Same-cycle bytes on both ports: only the terminal command may run
    exp_q.push_back({3'h1, OP_READ_MODE});
    fork
      trm.send('{OP_READ_MODE, CMD_TERM});
      hst.send('{OP_PARAM_MODE, CMD_TERM});
    join
    drain(1'b1);
    // Save with enable held low: the copy must wait out the frozen cycles
    exp_q.push_back({3'h5, OP_SAVE});
    trm.send('{OP_SAVE, CMD_TERM});
    ce = 1'b0;
    repeat (n_ce) @(posedge i_clock);
    #1;
    ce = 1'b1;
    repeat (7) @(posedge i_clock);
    #1;
    cmp_level(1'b0, saved, "save advanced while enable low");
    @(posedge i_clock);
    #1;
    cmp_level(1'b1, saved, "save not done after eight enabled cycles");
    drain(1'b1);
    exp_q.push_back(11'h200);
    trm.send('{8'h41, CMD_TERM});
    exp_q.push_back(11'h200);
    hst.send('{OP_WRITE, 8'h08, v2, CMD_TERM});
    exp_q.push_back({3'h1, QUERY_TAG ^ v1});
    trm.send('{OP_QUERY, CMD_TERM});
    exp_q.push_back({3'h1, OP_WRITE});
    trm.send('{OP_WRITE, 8'h00, v2, CMD_TERM});
    drain(1'b1);
    reset_dut(); // Unsaved write must be lost
    exp_q.push_back({3'h1, QUERY_TAG ^ v1});
    hst.send('{OP_QUERY, CMD_TERM});
    drain(1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
